// >>> core/emtor_regs.sv
// Purpose: miscellaneous error mask and two zone temperature offset registers
// Assumes: byte register port driven by the serial management front end
// Notes: event outputs and adjusted temperatures lag inputs by one clock
`timescale 1ns/10ps
`default_nettype none
`include "emtor_consts.svh"
module emtor_regs (
	input  wire logic                      sys_clk,
	input  wire logic                      arst_n,
	input  wire emtor_pkg::emtor_byte_type regAddr,
	input  wire emtor_pkg::emtor_byte_type regWdata,
	input  wire logic                      regWrite,
	input  wire logic                      regRead,
	output var  emtor_pkg::emtor_byte_type regRdata,
	output var  logic                      regHit,
	input  wire emtor_pkg::emtor_event_type rawEvent,
	output var  emtor_pkg::emtor_event_type maskedEvent,
	input  wire emtor_pkg::emtor_temp_type zoneATemp,
	input  wire logic                      zoneAValid,
	input  wire emtor_pkg::emtor_temp_type zoneBTemp,
	input  wire logic                      zoneBValid,
	output var  emtor_pkg::emtor_temp_type zoneAAdj,
	output var  logic                      zoneAAdjValid,
	output var  emtor_pkg::emtor_temp_type zoneBAdj,
	output var  logic                      zoneBAdjValid,
	output var  logic [5:0]                errorMask
);
	import emtor_pkg::*;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [5:0] zoneATempOffset;
	logic [5:0] zoneBTempOffset;
	emtor_byte_type next_regRdata;
	logic           next_regHit;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			errorMask <= `EMTOR_RST_MISC_MASK;
		end else if (regWrite && regAddr == `EMTOR_ADDR_MISC_MASK) begin
			errorMask <= regWdata[5:0];
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			zoneATempOffset <= `EMTOR_RST_ZONE_OFS;
			zoneBTempOffset <= `EMTOR_RST_ZONE_OFS;
		end else if (regWrite) begin
			if (regAddr == `EMTOR_ADDR_ZONE_A_OFS)
				zoneATempOffset <= regWdata[5:0];
			if (regAddr == `EMTOR_ADDR_ZONE_B_OFS)
				zoneBTempOffset <= regWdata[5:0];
		end
	end

	// ----------------------------------------
	// readback; reserved bits 7:6 read zero
	// ----------------------------------------
	always_comb begin
		next_regHit = 1'b1;
		case (regAddr)
			`EMTOR_ADDR_MISC_MASK:  next_regRdata = {2'h0, errorMask};
			`EMTOR_ADDR_ZONE_A_OFS: next_regRdata = {2'h0, zoneATempOffset};
			`EMTOR_ADDR_ZONE_B_OFS: next_regRdata = {2'h0, zoneBTempOffset};
			default: begin
				next_regRdata = 8'h00;
				next_regHit   = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdata <= 8'h00;
			regHit   <= 1'b0;
		end else if (regRead) begin
			regRdata <= next_regRdata;
			regHit   <= next_regHit;
		end
	end

	// ----------------------------------------
	// event masking, one gate per source
	// bit order: hot a, hot b, term a, term b, core volt a, core volt b
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < `EMTOR_MASK_W; i++) begin : gMask
			always_ff @(posedge sys_clk or negedge arst_n) begin
				if (!arst_n)
					maskedEvent[i] <= 1'b0;
				else
					maskedEvent[i] <= rawEvent[i] & ~errorMask[i];
			end
		end
	endgenerate

	// ----------------------------------------
	// zone offsets applied as each sample is produced; downstream
	// readback, limits and fan control see only the adjusted value
	// ----------------------------------------
	emtor_offset_add uZoneA (
		.sys_clk  (sys_clk),
		.arst_n   (arst_n),
		.rawTemp  (zoneATemp),
		.rawValid (zoneAValid),
		.offset   (zoneATempOffset),
		.adjTemp  (zoneAAdj),
		.adjValid (zoneAAdjValid)
	);

	emtor_offset_add uZoneB (
		.sys_clk  (sys_clk),
		.arst_n   (arst_n),
		.rawTemp  (zoneBTemp),
		.rawValid (zoneBValid),
		.offset   (zoneBTempOffset),
		.adjTemp  (zoneBAdj),
		.adjValid (zoneBAdjValid)
	);
endmodule : emtor_regs
`default_nettype wire

// >>> pkg/emtor_consts.svh
// Purpose: constants for the error mask and temperature offset register bank
// Assumes: 8-bit register port from the serial management front end
// Notes: offsets are byte addresses of the register space
// How it works
// - mask bit 0 blocks regulator hot a
// - mask bit 1 blocks regulator hot b
// - mask bit 2 blocks termination a
// - mask bit 3 blocks termination b
// - bits 4,5 block core voltage limits
// - zone a offset added to each sample
// - zone b offset added to each sample
// - adjusted temperature feeds all downstream users
// - offset is signed six bits, bits 5:0
`ifndef EMTOR_CONSTS_SVH
`define EMTOR_CONSTS_SVH
`define EMTOR_ADDR_MISC_MASK   8'hED
`define EMTOR_ADDR_ZONE_A_OFS  8'hEE
`define EMTOR_ADDR_ZONE_B_OFS  8'hEF
`define EMTOR_RST_MISC_MASK    6'h3F
`define EMTOR_RST_ZONE_OFS     6'h00
`define EMTOR_MASK_W           6
`define EMTOR_OFS_W            6
`define EMTOR_TEMP_MAX         8'sh7F
`define EMTOR_TEMP_MIN         8'sh80
`endif

// >>> pkg/emtor_pkg.sv
// Purpose: types for the error mask and temperature offset register bank
// Assumes: nothing
// Notes: temperatures are 8-bit signed whole degrees
package emtor_pkg;
	typedef logic [7:0]        emtor_byte_type;
	typedef logic signed [7:0] emtor_temp_type;
	typedef logic [5:0]        emtor_event_type;
endpackage : emtor_pkg

// >>> core/emtor_offset_add.sv
// Purpose: adds a signed offset to one zone temperature sample
// Assumes: sample and offset are two's complement
// Notes: result saturates rather than wrapping
`timescale 1ns/10ps
`default_nettype none
`include "emtor_consts.svh"
module emtor_offset_add (
	input  wire logic                    sys_clk,
	input  wire logic                    arst_n,
	input  wire emtor_pkg::emtor_temp_type rawTemp,
	input  wire logic                    rawValid,
	input  wire logic [5:0]              offset,
	output var  emtor_pkg::emtor_temp_type adjTemp,
	output var  logic                    adjValid
);
	import emtor_pkg::*;
	logic signed [8:0] sum;
	emtor_temp_type    next_adjTemp;

	// sign-extend the offset; span +31..-32 degrees
	assign sum = 9'(rawTemp) + {{3{offset[5]}}, offset};
	// saturate so a hot reading near full scale never wraps to cold
	always_comb begin
		if (sum > 9'sd127)
			next_adjTemp = `EMTOR_TEMP_MAX;
		else if (sum < -9'sd128)
			next_adjTemp = `EMTOR_TEMP_MIN;
		else
			next_adjTemp = sum[7:0];
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			adjTemp  <= 8'sh00;
			adjValid <= 1'b0;
		end else begin
			adjValid <= rawValid;
			if (rawValid)
				adjTemp <= next_adjTemp;
		end
	end
endmodule : emtor_offset_add
`default_nettype wire

// >>> test/emtor_regs_properties.sv
// Purpose: checker for the mask and zone offset bank
// Assumes: one clock, reset active low
// Notes: offset is internal, so sums are judged by the bench
`timescale 1ns/10ps
`default_nettype none
module emtor_regs_properties (
	input wire logic       sys_clk,
	input wire logic       arst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic       regWrite,
	input wire logic       regRead,
	input wire logic [7:0] regRdata,
	input wire logic [5:0] rawEvent,
	input wire logic [5:0] maskedEvent,
	input wire logic [5:0] errorMask,
	input wire logic       zoneAValid,
	input wire logic       zoneAAdjValid,
	input wire logic [7:0] zoneAAdj
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	chk_hot_mask: assert property ((maskedEvent & 6'h03) ==
		($past(rawEvent) & ~$past(errorMask) & 6'h03)) else $error("hot mask");
	chk_term_mask: assert property ((maskedEvent & 6'h0C) ==
		($past(rawEvent) & ~$past(errorMask) & 6'h0C)) else $error("term mask");
	chk_core_mask: assert property ((maskedEvent & 6'h30) ==
		($past(rawEvent) & ~$past(errorMask) & 6'h30)) else $error("core mask");
	chk_mask_write: assert property (regWrite && regAddr == 8'hED |=>
		{2'h0, errorMask} == ($past(regWdata) & 8'h3F)) else $error("mask write");
	chk_mask_reset: assert property ($rose(arst_n) |-> errorMask == 6'h3F)
		else $error("mask reset");
	chk_adj_valid: assert property (zoneAAdjValid == $past(zoneAValid))
		else $error("adj valid");
	chk_adj_hold: assert property (!zoneAAdjValid |-> $stable(zoneAAdj))
		else $error("adj hold");
	chk_rsvd_zero: assert property (regRead |=> regRdata[7:6] == 2'h0)
		else $error("rsvd bits");
	cover property (regWrite && regAddr == 8'hED);
	cover property (zoneAValid);
	cover property (|maskedEvent);
endmodule : emtor_regs_properties
bind emtor_regs emtor_regs_properties i_chk (.*);
`default_nettype wire

// >>> test/tb.sv
// Purpose: bench for the mask and zone offset bank
// Assumes: strobes one cycle wide
// Notes: inputs move 1 ns after each rising edge
`timescale 1ns/10ps
`default_nettype none
module tb;
	import emtor_pkg::*;
	logic sys_clk = 0, arst_n = 0, regWrite = 0, regRead = 0, regHit;
	logic zoneAValid = 0, zoneBValid = 0, zoneAAdjValid, zoneBAdjValid;
	emtor_byte_type regAddr = 0, regWdata = 0, regRdata;
	emtor_event_type rawEvent = 0, maskedEvent, errorMask;
	emtor_temp_type zoneATemp = 0, zoneBTemp = 0, zoneAAdj, zoneBAdj;
	int nErrors = 0, checksDone = 0;
	emtor_regs i_emtor_regs (.*);
	always #4 sys_clk = ~sys_clk;
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checksDone++;
		if (got !== exp) begin
			nErrors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic tick(input int n = 1);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		{regWrite, regRead, regAddr, regWdata} = {w, !w, a, d};
		tick();
		{regWrite, regRead} = 2'h0;
		// let one edge pass so back-to-back calls never re-raise a strobe in one step
		tick();
	endtask : acc
	task automatic regsScn();
		logic [7:0] rv [3] = '{8'h3F, 8'h00, 8'h00};
		for (int i = 0; i < 3; i++) begin
			acc(0, 8'(8'hED + i), 8'h00);
			cmp(regRdata, rv[i]);
			cmp({7'h00, regHit}, 8'h01);
			acc(1, 8'(8'hED + i), 8'hFF);
			acc(0, 8'(8'hED + i), 8'h00);
			cmp(regRdata, 8'h3F);
		end
		acc(0, 8'hE0, 8'h00);
		cmp({7'h00, regHit}, 8'h00);
	endtask : regsScn
	task automatic maskScn();
		for (int b = 0; b < 6; b++) begin
			acc(1, 8'hED, 8'h3F ^ (8'h01 << b));
			rawEvent = 6'h3F;
			tick(2);
			cmp(maskedEvent, 8'h01 << b);
			rawEvent = 6'h00;
		end
	endtask : maskScn
	task automatic tempScn();
		// offset, raw, expected; last row saturates
		logic [23:0] tv [4] = '{24'h3E504E, 24'h1F102F, 24'h2000E0, 24'h1F707F};
		for (int i = 0; i < 8; i++) begin
			acc(1, 8'(8'hEE + i[0]), tv[i / 2][23:16]);
			{zoneATemp, zoneBTemp} = {2{tv[i / 2][15:8]}};
			{zoneAValid, zoneBValid} = i[0] ? 2'b01 : 2'b10;
			tick();
			{zoneAValid, zoneBValid} = 2'b00;
			cmp(i[0] ? zoneBAdj : zoneAAdj, tv[i / 2][7:0]);
		end
	endtask : tempScn
	task automatic closeOut();
		if (nErrors == 0 && checksDone > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : closeOut
	initial begin
		tick(4);
		arst_n = 1;
		regsScn();
		maskScn();
		tempScn();
		closeOut();
	end
	initial begin
		#5000;
		nErrors++;
		closeOut();
	end
endmodule : tb
`default_nettype wire
